// ==== ue0_pkg.sv ====
// Package: register map, field positions, reset values and timing for the endpoint 0 block
package ue0_pkg;

   // Register byte addresses
   localparam logic [11:0] EP0_CSR_ADDR  = 12'h000;
   localparam logic [11:0] INFO_ADDR     = 12'h004;
   localparam logic [11:0] IRQ_STAT_ADDR = 12'h008;
   localparam logic [11:0] IRQ_MASK_ADDR = 12'h00C;

   // Endpoint 0 control/status field positions
   localparam int PING_DISABLE_BIT   = 27;
   localparam int TOGGLE_WREN_BIT    = 26;
   localparam int TOGGLE_STATE_BIT   = 25;
   localparam int FIFO_FLUSH_BIT     = 24;
   localparam int SVC_SETUP_END_BIT  = 23;
   localparam int NAK_TIMEOUT_BIT    = 23;
   localparam int SVC_RECEIVE_BIT    = 22;
   localparam int STATUS_STAGE_BIT   = 22;
   localparam int SEND_STALL_BIT     = 21;
   localparam int REQUEST_PKT_BIT    = 21;
   localparam int SETUP_END_BIT      = 20;
   localparam int DATA_END_BIT       = 19;
   localparam int STALL_SENT_BIT     = 18;
   localparam int TX_PKT_READY_BIT   = 17;
   localparam int RX_PKT_READY_BIT   = 16;

   // Information register layout and reset values
   localparam int VBUS_LEN_LSB   = 24;
   localparam int CONN_WAIT_LSB  = 20;
   localparam int ID_DELAY_LSB   = 16;
   localparam logic [7:0] VBUS_LEN_RST  = 8'h3C;
   localparam logic [3:0] CONN_WAIT_RST = 4'h5;
   localparam logic [3:0] ID_DELAY_RST  = 4'hC;
   localparam logic [3:0] DMA_CHANNELS  = 4'h8;
   localparam logic [3:0] RAM_ADDR_BITS = 4'hC;
   localparam logic [3:0] RX_ENDPOINTS  = 4'h7;
   localparam logic [3:0] TX_ENDPOINTS  = 4'h7;

   // Interrupt status bit positions
   localparam int IRQ_SETUP_END = 0;
   localparam int IRQ_RX_READY  = 1;
   localparam int IRQ_NAK_TMO   = 2;
   localparam int IRQ_STALL     = 3;
   localparam int IRQ_TX_DONE   = 4;
   localparam int IRQ_WIDTH     = 5;

   // Timing: step sizes in picoseconds and the clock period
   localparam longint CLK_PERIOD_PS    = 50000;
   localparam longint VBUS_STEP_PS     = 546100000;
   localparam longint CONN_STEP_PS     = 533300;
   localparam longint ID_STEP_PS       = 64'sd4369000000;
   localparam int     VBUS_STEP_CYC    = int'(VBUS_STEP_PS / CLK_PERIOD_PS);
   localparam int     CONN_STEP_CYC_RAW = int'(CONN_STEP_PS / CLK_PERIOD_PS);
   localparam int     CONN_STEP_CYC    = (CONN_STEP_CYC_RAW < 1) ? 1 : CONN_STEP_CYC_RAW;
   localparam int     ID_STEP_CYC      = int'(ID_STEP_PS / CLK_PERIOD_PS);

   // Operating role of the controller
   typedef enum logic {ROLE_DEVICE, ROLE_HOST} ue0_role_t;

   // Events from the USB engine, one cycle each
   typedef struct packed {
      logic setup_end_flag;
      logic data_stage_end;
      logic stallSent;
      logic rxPacket;
      logic txDone;
      logic nakSeen;
      logic ackSeen;
      logic toggleFlip;
   } ue0_evt_t;

   // Controls to the USB engine
   typedef struct packed {
      logic pingDisable;
      logic statusStage;
      logic requestPacket;
      logic send_stall_a;
      logic txPacketReady;
      logic ep0Halted;
      logic toggleState;
      logic fifoPtrReset;
   } ue0_ctl_t;

endpackage

// ==== ue0_endpoint0.sv ====
// Endpoint 0 control/status, information register, timing ticks and interrupt logic
`timescale 1ns/1ps
module ue0_endpoint0
#(
   parameter int VBUS_STEP = ue0_pkg::VBUS_STEP_CYC,
   parameter int ID_STEP   = ue0_pkg::ID_STEP_CYC
)
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire ue0_pkg::ue0_role_t role,
   input  wire logic [4:0]        nakLimit,
   input  wire ue0_pkg::ue0_evt_t  usbEvt,
   input  wire logic              idPullupEnable,
   output ue0_pkg::ue0_ctl_t       usbCtl,
   output logic                   vbusPulseActive,
   output logic                   connectFilterTick,
   output logic                   idLevelValid,
   output logic                   irq
);
   import ue0_pkg::*;

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   wire isHost   = (role == ROLE_HOST);
   wire access   = psel && penable;
   wire wrEn     = access && pwrite;
   wire selCsr   = (paddr == EP0_CSR_ADDR);
   wire selInfo  = (paddr == INFO_ADDR);
   wire selStat  = (paddr == IRQ_STAT_ADDR);
   wire selMask  = (paddr == IRQ_MASK_ADDR);
   wire mapped   = selCsr || selInfo || selStat || selMask;
   wire wrCsr    = wrEn && selCsr;
   wire wrInfo   = wrEn && selInfo;
   wire wrStat   = wrEn && selStat && pstrb[0];
   wire wrMask   = wrEn && selMask && pstrb[0];
   wire wrCsrHi  = wrCsr && pstrb[3];
   wire wrCsrMid = wrCsr && pstrb[2];

   // Zero-wait slave; unmapped addresses answer with an error
   assign pready  = 1'b1;
   assign pslverr = access && !mapped;

   // ------------------------------------------------------------
   // Control/status state
   // ------------------------------------------------------------
   logic pingDisable_q, toggleWren_q, toggle_q, flush_q;
   logic send_stall_a_q, setup_end_flag_q, data_stage_end_q, stallSent_q;
   logic txReady_q, rxReady_q, nakTmo_q, statusStage_q, request_packet_q;
   logic [4:0] nakCount_q;

   // Writes of one to self-clearing controls
   wire wTwren = wrCsrHi && pwdata[TOGGLE_WREN_BIT];
   wire wFlush = wrCsrHi && pwdata[FIFO_FLUSH_BIT];
   wire w23    = wrCsrMid && pwdata[SVC_SETUP_END_BIT];
   wire w22    = wrCsrMid && pwdata[SVC_RECEIVE_BIT];
   wire w21    = wrCsrMid && pwdata[SEND_STALL_BIT];

   wire svcSetupEnd = w23 && !isHost;
   wire svcReceive  = w22 && !isHost;

   // NAK counting against the external limit
   wire nakExpire = isHost && usbEvt.nakSeen && (nakCount_q >= nakLimit) && (nakLimit != 5'h00);

   // Flush completes in the cycle after the request
   wire flushDone = flush_q;

   // ------------------------------------------------------------
   // Host/device shared control bits
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pingDisable_q <= 1'b0;
         toggleWren_q  <= 1'b0;
         flush_q       <= 1'b0;
         send_stall_a_q   <= 1'b0;
         statusStage_q <= 1'b0;
         request_packet_q      <= 1'b0;
      end
      else
      begin
         if (wrCsrHi)
            pingDisable_q <= pwdata[PING_DISABLE_BIT] && isHost;
         // enable stands until the next write loads the toggle
         if (wrCsrHi)
            toggleWren_q <= !toggleWren_q && wTwren && isHost;
         flush_q <= wFlush && !flush_q;
         if (wrCsrMid && !isHost)
            send_stall_a_q <= pwdata[SEND_STALL_BIT];
         // status stage rides with tx ready or request
         if (wrCsrMid && isHost)
            statusStage_q <= pwdata[STATUS_STAGE_BIT];
         else if (usbEvt.txDone || usbEvt.rxPacket)
            statusStage_q <= 1'b0;
         if (w21 && isHost)
            request_packet_q <= 1'b1;
         else if (usbEvt.rxPacket || nakTmo_q)
            request_packet_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Data toggle and packet ready flags
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         toggle_q  <= 1'b0;
         txReady_q <= 1'b0;
         rxReady_q <= 1'b0;
      end
      else
      begin
         // toggle loads only while write enable is set
         if (toggleWren_q && wrCsrHi)
            toggle_q <= pwdata[TOGGLE_STATE_BIT];
         else if (usbEvt.toggleFlip)
            toggle_q <= !toggle_q;
         // flush clears whichever ready flag is set
         if (wrCsrMid && pwdata[TX_PKT_READY_BIT])
            txReady_q <= 1'b1;
         else if (usbEvt.txDone || flushDone)
            txReady_q <= 1'b0;
         // serviced receive clears rx ready; new packet wins
         if (usbEvt.rxPacket)
            rxReady_q <= 1'b1;
         else if (svcReceive || flushDone)
            rxReady_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Hardware-set status flags
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         setup_end_flag_q  <= 1'b0;
         data_stage_end_q   <= 1'b0;
         stallSent_q <= 1'b0;
         nakTmo_q    <= 1'b0;
         nakCount_q  <= 5'h00;
      end
      else
      begin
         // serviced setup end clears; a new event wins
         if (usbEvt.setup_end_flag && !isHost)
            setup_end_flag_q <= 1'b1;
         else if (svcSetupEnd)
            setup_end_flag_q <= 1'b0;
         if (usbEvt.data_stage_end)
            data_stage_end_q <= 1'b1;
         else if (wrCsrMid && !pwdata[DATA_END_BIT])
            data_stage_end_q <= 1'b0;
         if (usbEvt.stallSent)
            stallSent_q <= 1'b1;
         else if (wrCsrMid && !pwdata[STALL_SENT_BIT])
            stallSent_q <= 1'b0;
         // timeout sets on expiry, software writes zero to resume
         if (nakExpire)
            nakTmo_q <= 1'b1;
         else if (wrCsrMid && isHost && !pwdata[NAK_TIMEOUT_BIT])
            nakTmo_q <= 1'b0;
         if (!isHost || usbEvt.ackSeen || nakTmo_q)
            nakCount_q <= 5'h00;
         else if (usbEvt.nakSeen && nakCount_q != 5'h1F)
            nakCount_q <= nakCount_q + 5'h01;
      end
   end

   // ------------------------------------------------------------
   // Outputs to the USB engine
   // ------------------------------------------------------------
   // PING suppression only in host role
   assign usbCtl.pingDisable   = pingDisable_q && isHost;
   assign usbCtl.statusStage   = statusStage_q && isHost && (txReady_q || request_packet_q);
   assign usbCtl.requestPacket = request_packet_q;
   assign usbCtl.send_stall_a     = send_stall_a_q;
   assign usbCtl.txPacketReady = txReady_q;
   // endpoint halts while the timeout flag stands
   assign usbCtl.ep0Halted     = nakTmo_q;
   assign usbCtl.toggleState   = toggle_q;
   assign usbCtl.fifoPtrReset  = flush_q;

   // ------------------------------------------------------------
   // Information register fields
   // ------------------------------------------------------------
   logic [7:0] vbusLen_q;
   logic [3:0] connWait_q;
   logic [3:0] idDelay_q;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         vbusLen_q  <= VBUS_LEN_RST;
         connWait_q <= CONN_WAIT_RST;
         idDelay_q  <= ID_DELAY_RST;
      end
      else
      begin
         if (wrInfo && pstrb[3])
            vbusLen_q <= pwdata[VBUS_LEN_LSB +: 8];
         if (wrInfo && pstrb[2])
         begin
            connWait_q <= pwdata[CONN_WAIT_LSB +: 4];
            idDelay_q  <= pwdata[ID_DELAY_LSB +: 4];
         end
      end
   end

   // ------------------------------------------------------------
   // Timing generators from the step counts
   // ------------------------------------------------------------
   // Step prescaler: one-cycle tick at each step boundary
   function automatic logic [31:0] stepNext(input logic [31:0] cnt, input int step);
      stepNext = (cnt >= 32'(step - 1)) ? 32'h0000_0000 : cnt + 32'h0000_0001;
   endfunction

   logic [31:0] vbusPre_q, connPre_q, idPre_q;
   logic [7:0]  vbusSteps_q;
   logic [3:0]  connSteps_q, idSteps_q;
   logic        vbusRun_q, idPullPrev_q;
   wire vbusTick = (vbusPre_q == 32'(VBUS_STEP - 1));
   wire connTick = (connPre_q == 32'(CONN_STEP_CYC - 1));
   wire idTick   = (idPre_q == 32'(ID_STEP - 1));
   // Last step of the filter wait; a zero wait ticks every step
   wire connLast = ({1'b0, connSteps_q} + 5'h01 >= {1'b0, connWait_q});
   // A VBUS pulse starts when software writes a nonzero length field
   wire vbusStart = wrInfo && pstrb[3];

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         vbusPre_q   <= 32'h0000_0000;
         connPre_q   <= 32'h0000_0000;
         idPre_q     <= 32'h0000_0000;
         vbusSteps_q <= 8'h00;
         connSteps_q <= 4'h0;
         idSteps_q   <= 4'h0;
         vbusRun_q   <= 1'b0;
         idPullPrev_q <= 1'b0;
      end
      else
      begin
         idPullPrev_q <= idPullupEnable;
         // VBUS pulse lasts length times step
         vbusPre_q <= (vbusStart || !vbusRun_q) ? 32'h0000_0000 : stepNext(vbusPre_q, VBUS_STEP);
         if (vbusStart)
         begin
            vbusSteps_q <= pwdata[VBUS_LEN_LSB +: 8];
            vbusRun_q   <= (pwdata[VBUS_LEN_LSB +: 8] != 8'h00);
         end
         else if (vbusRun_q && vbusTick)
         begin
            vbusSteps_q <= vbusSteps_q - 8'h01;
            vbusRun_q   <= (vbusSteps_q != 8'h01);
         end
         // filter tick every wait count of steps
         connPre_q <= stepNext(connPre_q, CONN_STEP_CYC);
         if (connTick)
            connSteps_q <= connLast ? 4'h0 : connSteps_q + 4'h1;
         // ID valid after delay from pull-up enable
         if (!idPullupEnable || (idPullupEnable && !idPullPrev_q))
         begin
            idPre_q   <= 32'h0000_0000;
            idSteps_q <= 4'h0;
         end
         else if (idSteps_q < idDelay_q)
         begin
            idPre_q <= stepNext(idPre_q, ID_STEP);
            if (idTick)
               idSteps_q <= idSteps_q + 4'h1;
         end
      end
   end

   assign vbusPulseActive   = vbusRun_q;
   assign connectFilterTick = connTick && connLast;
   assign idLevelValid      = idPullupEnable && idPullPrev_q && (idSteps_q >= idDelay_q);

   // ------------------------------------------------------------
   // Interrupt status and mask
   // ------------------------------------------------------------
   logic [IRQ_WIDTH-1:0] irqStat_q, irqMask_q;
   wire  [IRQ_WIDTH-1:0] irqSet = {usbEvt.txDone, usbEvt.stallSent, nakExpire,
                                   usbEvt.rxPacket, usbEvt.setup_end_flag};

   // New events win over a write-one clear
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         irqStat_q <= '0;
         irqMask_q <= '0;
      end
      else
      begin
         irqStat_q <= irqSet | (irqStat_q & ~(wrStat ? pwdata[IRQ_WIDTH-1:0] : '0));
         if (wrMask)
            irqMask_q <= pwdata[IRQ_WIDTH-1:0];
      end
   end

   assign irq = |(irqStat_q & irqMask_q);

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   logic [31:0] csrRd, infoRd;
   always_comb
   begin
      // upper nibble and low half read zero
      csrRd = 32'h0000_0000;
      csrRd[PING_DISABLE_BIT] = pingDisable_q;
      csrRd[TOGGLE_WREN_BIT]  = toggleWren_q;
      csrRd[TOGGLE_STATE_BIT] = toggle_q;
      csrRd[FIFO_FLUSH_BIT]   = flush_q;
      csrRd[23] = isHost ? nakTmo_q : 1'b0;
      csrRd[22] = isHost ? statusStage_q : 1'b0;
      csrRd[21] = isHost ? request_packet_q : send_stall_a_q;
      csrRd[SETUP_END_BIT]    = setup_end_flag_q;
      csrRd[DATA_END_BIT]     = data_stage_end_q;
      csrRd[STALL_SENT_BIT]   = stallSent_q;
      csrRd[TX_PKT_READY_BIT] = txReady_q;
      csrRd[RX_PKT_READY_BIT] = rxReady_q;
      infoRd = {vbusLen_q, connWait_q, idDelay_q, DMA_CHANNELS, RAM_ADDR_BITS,
                RX_ENDPOINTS, TX_ENDPOINTS};
   end

   wire [31:0] rdMux = selCsr  ? csrRd :
                       selInfo ? infoRd :
                       selStat ? {27'h0, irqStat_q} :
                       selMask ? {27'h0, irqMask_q} : 32'h0000_0000;

   // Registered read data, loaded during setup so it is ready at access
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
         prdata <= rdMux;
   end

endmodule

// ==== ue0_usb_engine.sv ====
// Behavioural model of the USB engine that faces endpoint 0
`timescale 1ns/1ps
module ue0_usb_engine
#(
   parameter int TX_LAT = 64
)
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire ue0_pkg::ue0_evt_t evtReq,
   input  wire ue0_pkg::ue0_ctl_t usbCtl,
   output ue0_pkg::ue0_evt_t      usbEvt
);
   import ue0_pkg::*;

   int txWait;

   // Bench pulses pass one cycle late; a queued packet goes out after TX_LAT
   // Halted endpoint sends nothing, so no done pulse while halted
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         usbEvt <= '0;
         txWait <= 0;
      end
      else
      begin
         usbEvt <= evtReq;
         txWait <= (usbCtl.txPacketReady && !usbCtl.ep0Halted) ? txWait + 1 : 0;
         if (txWait == TX_LAT)
            usbEvt.txDone <= 1'b1;
      end
   end
endmodule

// ==== ue0_endpoint0_asserts.sv ====
// Port-level checker for the endpoint 0 block
`timescale 1ns/1ps
module ue0_endpoint0_asserts
#(
   parameter int VBUS_STEP = 4,
   parameter int ID_STEP   = 4
)
(
   input wire logic              clk,
   input wire logic              rst_n,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [11:0]       paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [3:0]        pstrb,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire ue0_pkg::ue0_role_t role,
   input wire logic [4:0]        nakLimit,
   input wire ue0_pkg::ue0_evt_t usbEvt,
   input wire logic              idPullupEnable,
   input wire ue0_pkg::ue0_ctl_t usbCtl,
   input wire logic              vbusPulseActive,
   input wire logic              connectFilterTick,
   input wire logic              idLevelValid,
   input wire logic              irq
);
   import ue0_pkg::*;

   logic csrWr;
   logic lastWren;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // ----------------------------------------
   // Helper logic
   // ----------------------------------------
   assign csrWr = psel && penable && pwrite && paddr == EP0_CSR_ADDR && pstrb[3];

   // Mirrors the toggle enable: a host write arms it, the next write uses it
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         lastWren <= 1'b0;
      else if (csrWr)
         lastWren <= !lastWren && pwdata[TOGGLE_WREN_BIT] && role == ROLE_HOST;
   end

   // ----------------------------------------
   // Sequences and properties
   // ----------------------------------------
   sequence csrRead;
      psel && !penable && !pwrite && paddr == EP0_CSR_ADDR;
   endsequence
   sequence flushReq;
      csrWr && pwdata[FIFO_FLUSH_BIT] && !pwdata[TX_PKT_READY_BIT];
   endsequence
   sequence ptrResetThenClear;
      ##[1:2] usbCtl.fifoPtrReset ##[0:2] !usbCtl.txPacketReady;
   endsequence
   property toggleLoad;
      logic b;
      (csrWr && role == ROLE_HOST && lastWren && pwdata[TOGGLE_WREN_BIT],
       b = pwdata[TOGGLE_STATE_BIT]) |=> usbCtl.toggleState == b;
   endproperty

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   AST_CSR_UNUSED_ZERO:
      assert property (csrRead |=> prdata[31:28] == 4'h0 && prdata[15:0] == 16'h0000)
         else $error("unused endpoint 0 bits read nonzero");
   AST_INFO_FIXED:
      assert property (psel && !penable && !pwrite && paddr == INFO_ADDR
                       |=> prdata[15:0] == 16'h8C77)
         else $error("info read-only counts wrong");
   AST_PING_HOST_ONLY:
      assert property (usbCtl.pingDisable |-> role == ROLE_HOST)
         else $error("ping disable active outside host role");
   AST_PING_SET:
      assert property (csrWr && role == ROLE_HOST && pwdata[PING_DISABLE_BIT]
                       |=> usbCtl.pingDisable)
         else $error("ping disable not applied");
   AST_FLUSH_SEQ:
      assert property (flushReq |-> ptrResetThenClear)
         else $error("flush did not reset pointer and clear ready");
   AST_STATUS_HOST_ONLY:
      assert property (usbCtl.statusStage |-> role == ROLE_HOST)
         else $error("status stage request outside host role");
   AST_HALT_NEEDS_LIMIT:
      assert property ($rose(usbCtl.ep0Halted) |-> nakLimit != 5'h00 && role == ROLE_HOST)
         else $error("endpoint halted without a NAK limit");
   AST_TOGGLE_LOCKED:
      assert property (csrWr && !pwdata[TOGGLE_WREN_BIT] && !lastWren && !usbEvt.toggleFlip
                       |=> $stable(usbCtl.toggleState))
         else $error("toggle changed without write enable");
   AST_TOGGLE_LOAD:
      assert property (toggleLoad)
         else $error("enabled toggle write not loaded");
   AST_ID_AFTER_PULLUP:
      assert property ($rose(idLevelValid) |-> $past(idPullupEnable))
         else $error("id level valid without pull-up");
endmodule

bind ue0_endpoint0 ue0_endpoint0_asserts #(.VBUS_STEP(VBUS_STEP), .ID_STEP(ID_STEP)) chk_i (
   .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .role(role), .nakLimit(nakLimit), .usbEvt(usbEvt),
   .idPullupEnable(idPullupEnable), .usbCtl(usbCtl), .vbusPulseActive(vbusPulseActive),
   .connectFilterTick(connectFilterTick), .idLevelValid(idLevelValid), .irq(irq));

// ==== ue0_endpoint0_test.sv ====
// Self-checking register-level bench for the endpoint 0 block
`timescale 1ns/1ps
module ue0_endpoint0_test;
   import ue0_pkg::*;

   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0]  pstrb = '0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   ue0_role_t   role = ROLE_DEVICE;
   logic [4:0]  nakLimit = '0;
   ue0_evt_t    evtReq = '0;
   ue0_evt_t    usbEvt;
   logic        idPullupEnable = 1'b0;
   ue0_ctl_t    usbCtl;
   logic        vbusPulseActive;
   logic        connectFilterTick;
   logic        idLevelValid;
   logic        irq;
   logic [31:0] rd;
   logic        er;
   int          cyc;
   int          n_mismatch = 0;
   int          n_tests = 0;

   // 20 MHz clock
   always #25 clk = ~clk;

   ue0_endpoint0 #(.VBUS_STEP(4), .ID_STEP(4)) dut (
      .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .role(role), .nakLimit(nakLimit), .usbEvt(usbEvt),
      .idPullupEnable(idPullupEnable), .usbCtl(usbCtl), .vbusPulseActive(vbusPulseActive),
      .connectFilterTick(connectFilterTick), .idLevelValid(idLevelValid), .irq(irq));

   ue0_usb_engine #(.TX_LAT(64)) eng (
      .clk(clk), .rst_n(rst_n), .evtReq(evtReq), .usbCtl(usbCtl), .usbEvt(usbEvt));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= 4'hF;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic ev(input ue0_evt_t e);
      @(posedge clk) evtReq <= e;
      @(posedge clk) evtReq <= '0;
   endtask

   task automatic finish_test();
      $display("mismatches %0d, comparisons %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Watchdog well beyond the expected run
   initial
   begin
      #(20000 * 50);
      n_mismatch++;
      finish_test();
   end

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial
   begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, INFO_ADDR, 32'h0);
      chk("info reset", rd, 32'h3C5C_8C77);
      apb(1'b0, EP0_CSR_ADDR, 32'h0);
      chk("csr reset", rd, 32'h0000_0000);
      // Writable fields take all ones, counts stay fixed
      apb(1'b1, INFO_ADDR, 32'hFFFF_FFFF);
      apb(1'b0, INFO_ADDR, 32'h0);
      chk("info write", rd, 32'hFFFF_8C77);
      chk("vbus pulse on", vbusPulseActive, 32'h1);
      repeat (990) @(posedge clk);
      chk("vbus pulse held", vbusPulseActive, 32'h1);
      repeat (40) @(posedge clk);
      chk("vbus pulse end", vbusPulseActive, 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      chk("unmapped err", er, 32'h1);
      chk("unmapped data", rd, 32'h0);
      // Device role: setup end flag, interrupt, serviced clear
      ev('{setup_end_flag: 1'b1, default: 1'b0});
      apb(1'b0, EP0_CSR_ADDR, 32'h0);
      chk("setup end set", rd, 32'h0010_0000);
      apb(1'b1, IRQ_MASK_ADDR, 32'h0000_001F);
      @(posedge clk) chk("irq unmasked", irq, 32'h1);
      apb(1'b1, IRQ_MASK_ADDR, 32'h0000_0000);
      @(posedge clk) chk("irq masked", irq, 32'h0);
      apb(1'b1, IRQ_MASK_ADDR, 32'h0000_001F);
      apb(1'b0, IRQ_STAT_ADDR, 32'h0);
      chk("irq status", rd, 32'h0000_0001);
      apb(1'b1, EP0_CSR_ADDR, 32'h0080_0000);
      apb(1'b0, EP0_CSR_ADDR, 32'h0);
      chk("setup end serviced", rd, 32'h0000_0000);
      ev('{rxPacket: 1'b1, default: 1'b0});
      apb(1'b0, EP0_CSR_ADDR, 32'h0);
      chk("rx ready set", rd, 32'h0001_0000);
      apb(1'b1, EP0_CSR_ADDR, 32'h0040_0000);
      apb(1'b0, EP0_CSR_ADDR, 32'h0);
      chk("rx serviced", rd, 32'h0000_0000);
      // Flushes issued only while a ready flag is set
      ev('{rxPacket: 1'b1, default: 1'b0});
      apb(1'b1, EP0_CSR_ADDR, 32'h0100_0000);
      apb(1'b0, EP0_CSR_ADDR, 32'h0);
      chk("rx flush", rd, 32'h0000_0000);
      apb(1'b1, EP0_CSR_ADDR, 32'h0002_0000);
      apb(1'b1, EP0_CSR_ADDR, 32'h0100_0000);
      apb(1'b0, EP0_CSR_ADDR, 32'h0);
      chk("tx flush", rd, 32'h0000_0000);
      apb(1'b1, IRQ_STAT_ADDR, 32'h0000_001F);
      apb(1'b1, EP0_CSR_ADDR, 32'h0002_0000);
      repeat (80) @(posedge clk);
      apb(1'b0, IRQ_STAT_ADDR, 32'h0);
      chk("tx done irq", rd, 32'h0000_0010);
      chk("irq level", irq, 32'h1);
      apb(1'b1, IRQ_STAT_ADDR, 32'h0000_001F);
      @(posedge clk) chk("irq cleared", irq, 32'h0);
      // Host role: ping, toggle, status stage, NAK timeout
      @(posedge clk) role <= ROLE_HOST;
      apb(1'b1, EP0_CSR_ADDR, 32'h0800_0000);
      @(posedge clk) chk("ping disable", usbCtl.pingDisable, 32'h1);
      @(posedge clk) role <= ROLE_DEVICE;
      @(posedge clk) chk("ping device", usbCtl.pingDisable, 32'h0);
      @(posedge clk) role <= ROLE_HOST;
      apb(1'b1, EP0_CSR_ADDR, 32'h0C00_0000);
      apb(1'b1, EP0_CSR_ADDR, 32'h0E00_0000);
      apb(1'b0, EP0_CSR_ADDR, 32'h0);
      chk("toggle load", rd, 32'h0A00_0000);
      apb(1'b1, EP0_CSR_ADDR, 32'h0800_0000);
      apb(1'b0, EP0_CSR_ADDR, 32'h0);
      chk("toggle locked", rd, 32'h0A00_0000);
      apb(1'b1, EP0_CSR_ADDR, 32'h0842_0000);
      @(posedge clk) chk("status stage", {usbCtl.statusStage, usbCtl.txPacketReady}, 32'h3);
      repeat (4) ev('{nakSeen: 1'b1, default: 1'b0});
      apb(1'b0, EP0_CSR_ADDR, 32'h0);
      chk("no limit no halt", rd[NAK_TIMEOUT_BIT], 32'h0);
      nakLimit <= 5'h03;
      repeat (4) ev('{nakSeen: 1'b1, default: 1'b0});
      apb(1'b0, EP0_CSR_ADDR, 32'h0);
      chk("nak timeout", {rd[NAK_TIMEOUT_BIT], usbCtl.ep0Halted}, 32'h3);
      apb(1'b1, EP0_CSR_ADDR, 32'h0800_0000);
      apb(1'b0, EP0_CSR_ADDR, 32'h0);
      chk("nak cleared", {rd[NAK_TIMEOUT_BIT], usbCtl.ep0Halted}, 32'h0);
      // Id valid after fifteen steps of four cycles
      idPullupEnable <= 1'b1;
      repeat (5) @(posedge clk);
      chk("id early", idLevelValid, 32'h0);
      repeat (70) @(posedge clk);
      chk("id valid", idLevelValid, 32'h1);
      // Filter ticks are the written wait of fifteen steps apart
      while (connectFilterTick !== 1'b1)
         @(posedge clk);
      @(posedge clk);
      cyc = 1;
      while (connectFilterTick !== 1'b1)
      begin
         @(posedge clk);
         cyc++;
      end
      chk("filter period", 32'(cyc), 32'(15 * CONN_STEP_CYC));
      finish_test();
   end
endmodule
